// ==== ffb_pin_logic.sv ====
// pin-level bus logic of a 16-bit parallel boot block flash
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module ffb_pin_logic
  import ffb_pkg::*;
(
  input wire logic CORE_CLK_I, // 20 MHz core clock
  input wire logic NRST_I, // async reset, active low
  input wire logic [ADDR_W-1:0] ADDR_I, // address pins
  input wire logic [DATA_W-1:0] DQ_I, // data pins, input side
  output logic [DATA_W-1:0] DQ_O, // data pins, output side
  output logic DQ_OE_O, // data pins driven when high
  input wire logic CE_N_I, // chip select pin, low active
  input wire logic OE_N_I, // output enable pin, low active
  input wire logic WE_N_I, // write strobe pin, low active
  input wire logic ADDR_VALID_N_I, // address valid pin, low active
  input wire logic BURST_CLK_I, // burst clock pin, sampled
  input wire logic WP_N_I, // write protect pin, low active
  input wire logic RST_N_I, // device reset pin, low active
  input wire logic TOP_BOOT_I, // parameter blocks at top of map
  input wire logic CFG_WR_I, // load read configuration
  input wire ffb_read_cfg_t CFG_I, // read configuration value
  input wire logic MODE_WR_I, // load read mode
  input wire ffb_read_mode_t MODE_I, // read mode value
  input wire logic [DATA_W-1:0] ARRAY_DATA_I, // array word at latched address
  input wire logic [DATA_W-1:0] IDENT_DATA_I, // identifier word
  input wire logic BURST_DATA_VALID_I, // burst data ready
  input wire logic PGM_REQ_I, // program request pulse
  input wire logic ERASE_REQ_I, // block erase request pulse
  input wire logic STATUS_CLR_I, // clear status flags pulse
  output logic [ADDR_W-1:0] ADDR_O, // latched address
  output logic [DATA_W-1:0] WDATA_O, // latched write word
  output logic WSTROBE_O, // one-cycle pulse per completed write
  output logic BURST_START_O, // one-cycle pulse on burst address latch
  output logic BURST_STEP_O, // one-cycle pulse per active burst clock edge after the one that latches the address
  output logic PGM_GO_O, // program accepted pulse
  output logic ERASE_GO_O, // erase accepted pulse
  output logic [STAT_W-1:0] STATUS_O, // status byte
  output logic AUTO_RST_O, // automation held in reset
  output logic STANDBY_O, // device deselected
  output logic SYNC_MODE_O, // synchronous burst active
  output logic WAIT_N_O, // wait pin value, low = not ready
  output logic WAIT_OE_O // wait pin driven when high
);

  // ----------------------------------------------------------------
  // lock decode
  // ----------------------------------------------------------------
  function automatic logic is_lockable(input logic [ADDR_W-1:0] a, input logic top);
    logic [3:0] main_idx;
    logic [2:0] par_idx;
    logic in_param;
    logic par_lock;
    main_idx = a[MAIN_MSB:MAIN_LSB];
    par_idx = a[PARAM_MSB:PARAM_LSB];
    in_param = top ? (main_idx == MAIN_IDX_TOP) : (main_idx == MAIN_IDX_BOT);
    par_lock = top ? (par_idx == PARAM_LOCK_TOP_A || par_idx == PARAM_LOCK_TOP_B)
                   : (par_idx == PARAM_LOCK_BOT_A || par_idx == PARAM_LOCK_BOT_B);
    return !in_param || par_lock;
  endfunction : is_lockable

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  ffb_pins_t pins_raw;
  ffb_pins_t pins_s1;
  ffb_pins_t pins;
  ffb_pins_t pins_d;

  assign pins_raw = '{
    addr: ADDR_I,
    dq: DQ_I,
    ce_n: CE_N_I,
    oe_n: OE_N_I,
    we_n: WE_N_I,
    addr_valid_n: ADDR_VALID_N_I,
    bclk: BURST_CLK_I,
    wp_n: WP_N_I,
    rst_n: RST_N_I
  };

  // buses pass the same two stages as strobes so they stay aligned
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      pins_s1 <= PINS_IDLE;
      pins <= PINS_IDLE;
      pins_d <= PINS_IDLE;
    end
    else
    begin
      pins_s1 <= pins_raw;
      pins <= pins_s1;
      pins_d <= pins;
    end
  end

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  logic dev_rst;
  logic selected;
  logic adv_rise;
  logic we_rise;
  logic bclk_active_edge;
  logic writing;
  ffb_read_cfg_t cfg;
  ffb_read_mode_t read_mode;
  logic burst_latched;

  assign dev_rst = !pins.rst_n;
  assign selected = !pins.ce_n && !dev_rst;
  assign adv_rise = pins.addr_valid_n && !pins_d.addr_valid_n;
  assign we_rise = pins.we_n && !pins_d.we_n;
  assign writing = !pins.we_n || !pins_d.we_n;
  // clock only counts in burst mode and outside writes
  assign bclk_active_edge = cfg.sync_burst && !writing
    && (cfg.falling_edge ? (!pins.bclk && pins_d.bclk) : (pins.bclk && !pins_d.bclk));

  // ----------------------------------------------------------------
  // read configuration and mode
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      cfg <= CFG_RST;
    else if (dev_rst)
      cfg <= CFG_RST;
    else if (CFG_WR_I)
      cfg <= CFG_I;
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      read_mode <= RD_ARRAY;
    else if (dev_rst)
      read_mode <= RD_ARRAY;
    else if (MODE_WR_I)
      read_mode <= MODE_I;
  end

  // ----------------------------------------------------------------
  // address capture
  // ----------------------------------------------------------------
  // low addr_valid_n in page mode keeps the latch open, so a host that
  // ties it low still gets each new address
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ADDR_O <= ADDR_RST;
      burst_latched <= 1'b0;
      BURST_START_O <= 1'b0;
      BURST_STEP_O <= 1'b0;
    end
    else
    begin
      BURST_START_O <= 1'b0;
      BURST_STEP_O <= 1'b0;
      if (!selected)
        burst_latched <= 1'b0;
      else if (we_rise)
        ADDR_O <= pins_d.addr;
      else if (cfg.sync_burst)
      begin
        if (!burst_latched && !pins.addr_valid_n && bclk_active_edge)
        begin
          ADDR_O <= pins.addr;
          burst_latched <= 1'b1;
          BURST_START_O <= 1'b1;
        end
        else if (!burst_latched && adv_rise)
        begin
          ADDR_O <= pins_d.addr;
          burst_latched <= 1'b1;
          BURST_START_O <= 1'b1;
        end
        else if (burst_latched && bclk_active_edge)
          BURST_STEP_O <= 1'b1;
        if (burst_latched && !pins.addr_valid_n && pins_d.addr_valid_n)
          burst_latched <= 1'b0;
      end
      else if (adv_rise)
        ADDR_O <= pins_d.addr;
      else if (!pins.addr_valid_n && pins.we_n)
        ADDR_O <= pins.addr;
    end
  end

  // ----------------------------------------------------------------
  // write data capture
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      WDATA_O <= DATA_RST;
      WSTROBE_O <= 1'b0;
    end
    else
    begin
      WSTROBE_O <= 1'b0;
      if (selected && we_rise)
      begin
        WDATA_O <= pins_d.dq;
        WSTROBE_O <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // program / erase gating and status flags
  // ----------------------------------------------------------------
  logic locked;
  logic pgm_fail;
  logic erase_fail;

  // write protect high releases every block
  assign locked = !pins.wp_n && is_lockable(ADDR_O, TOP_BOOT_I);
  assign pgm_fail = PGM_REQ_I && locked;
  assign erase_fail = ERASE_REQ_I && locked;

  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      PGM_GO_O <= 1'b0;
      ERASE_GO_O <= 1'b0;
      AUTO_RST_O <= 1'b1;
    end
    else
    begin
      AUTO_RST_O <= dev_rst;
      PGM_GO_O <= PGM_REQ_I && !locked && !dev_rst;
      ERASE_GO_O <= ERASE_REQ_I && !locked && !dev_rst;
    end
  end

  // a failure in the clear cycle still sets its flag
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      STATUS_O <= STATUS_RST;
    else if (dev_rst)
      STATUS_O <= STATUS_RST;
    else
    begin
      if (STATUS_CLR_I)
        STATUS_O <= STATUS_RST;
      if (pgm_fail || erase_fail)
        STATUS_O[ST_LOCKED_BIT] <= 1'b1;
      if (pgm_fail)
        STATUS_O[ST_PGM_ERR_BIT] <= 1'b1;
      if (erase_fail)
        STATUS_O[ST_ERASE_ERR_BIT] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read data path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_dq;

  always_comb
  begin
    case (read_mode)
      RD_ARRAY: next_dq = ARRAY_DATA_I;
      RD_IDENT: next_dq = IDENT_DATA_I;
      RD_STATUS: next_dq = {8'h00, STATUS_O};
      default: next_dq = ARRAY_DATA_I;
    endcase
  end

  // write strobe low wins over output enable so a careless host cannot
  // provoke contention on the shared lines
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      DQ_O <= DATA_RST;
      DQ_OE_O <= 1'b0;
    end
    else
    begin
      DQ_O <= next_dq;
      DQ_OE_O <= selected && !pins.oe_n && pins.we_n;
    end
  end

  // ----------------------------------------------------------------
  // standby, mode and wait outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      STANDBY_O <= 1'b1;
      SYNC_MODE_O <= 1'b0;
      WAIT_N_O <= 1'b1;
      WAIT_OE_O <= 1'b0;
    end
    else
    begin
      STANDBY_O <= !selected;
      SYNC_MODE_O <= cfg.sync_burst;
      WAIT_OE_O <= selected && !pins.oe_n && cfg.sync_burst && cfg.continuous;
      WAIT_N_O <= BURST_DATA_VALID_I || !(cfg.sync_burst && cfg.continuous);
    end
  end

endmodule : ffb_pin_logic

// ==== ffb_pkg.sv ====
// shared constants and types for the flash bus pin logic
package ffb_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 19;
  localparam int DATA_W = 16;
  localparam int STAT_W = 8;

  // ----------------------------------------------------------------
  // block map fields (word address)
  // ----------------------------------------------------------------
  localparam int MAIN_MSB = 18;
  localparam int MAIN_LSB = 15;
  localparam int PARAM_MSB = 14;
  localparam int PARAM_LSB = 12;
  localparam logic [3:0] MAIN_IDX_TOP = 4'hF;
  localparam logic [3:0] MAIN_IDX_BOT = 4'h0;
  localparam logic [2:0] PARAM_LOCK_TOP_A = 3'h6;
  localparam logic [2:0] PARAM_LOCK_TOP_B = 3'h7;
  localparam logic [2:0] PARAM_LOCK_BOT_A = 3'h0;
  localparam logic [2:0] PARAM_LOCK_BOT_B = 3'h1;

  // ----------------------------------------------------------------
  // status byte bit positions and reset values
  // ----------------------------------------------------------------
  localparam int ST_LOCKED_BIT = 1;
  localparam int ST_PGM_ERR_BIT = 4;
  localparam int ST_ERASE_ERR_BIT = 5;
  localparam logic [STAT_W-1:0] STATUS_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RD_ARRAY,
    RD_IDENT,
    RD_STATUS
  } ffb_read_mode_t;

  // all pins that arrive from the host, synchronised together
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic addr_valid_n;
    logic bclk;
    logic wp_n;
    logic rst_n;
  } ffb_pins_t;

  localparam ffb_pins_t PINS_IDLE = '{
    addr: ADDR_RST,
    dq: DATA_RST,
    ce_n: 1'b1,
    oe_n: 1'b1,
    we_n: 1'b1,
    addr_valid_n: 1'b1,
    bclk: 1'b0,
    wp_n: 1'b0,
    rst_n: 1'b0
  };

  // read configuration as loaded by the command interface
  typedef struct packed {
    logic sync_burst;
    logic falling_edge;
    logic continuous;
  } ffb_read_cfg_t;

  localparam ffb_read_cfg_t CFG_RST = '{sync_burst: 1'b0, falling_edge: 1'b0, continuous: 1'b0};

endpackage : ffb_pkg

// ==== ffb_pin_logic_assertions.sv ====
// concurrent checks on the flash bus pin logic ports
module ffb_chk
  import ffb_pkg::*;
(
  input wire logic CORE_CLK_I, // core clock
  input wire logic NRST_I, // core reset
  input wire logic [ADDR_W-1:0] ADDR_I, // pin
  input wire logic [DATA_W-1:0] DQ_I, // pin
  input wire logic CE_N_I, // pin
  input wire logic OE_N_I, // pin
  input wire logic WE_N_I, // pin
  input wire logic WP_N_I, // pin
  input wire logic RST_N_I, // pin
  input wire logic TOP_BOOT_I, // map
  input wire logic CFG_WR_I, // core
  input wire logic PGM_REQ_I, // core
  input wire logic ERASE_REQ_I, // core
  input wire logic DQ_OE_O, // out
  input wire logic [ADDR_W-1:0] ADDR_O, // out
  input wire logic [DATA_W-1:0] WDATA_O, // out
  input wire logic WSTROBE_O, // out
  input wire logic PGM_GO_O, // out
  input wire logic ERASE_GO_O, // out
  input wire logic [STAT_W-1:0] STATUS_O, // out
  input wire logic AUTO_RST_O, // out
  input wire logic STANDBY_O, // out
  input wire logic SYNC_MODE_O, // out
  input wire logic WAIT_OE_O // out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // lock map and sequences
  // ----------------------------------------------------------------
  logic par_blk;
  logic lockable;
  assign par_blk = ADDR_O[MAIN_MSB:MAIN_LSB] == (TOP_BOOT_I ? MAIN_IDX_TOP : MAIN_IDX_BOT);
  // every main block and only the two outermost parameter blocks lock
  assign lockable = !par_blk || (TOP_BOOT_I ? ADDR_O[PARAM_MSB:PARAM_LSB] >= PARAM_LOCK_TOP_A
    : ADDR_O[PARAM_MSB:PARAM_LSB] <= PARAM_LOCK_BOT_B);
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_wp_lo; (!WP_N_I && RST_N_I)[*5]; endsequence
  sequence s_wr_edge; (!WE_N_I && !CE_N_I && RST_N_I)[*4] ##1 (WE_N_I && RST_N_I); endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_ce_hiz; CE_N_I[*5] |-> !DQ_OE_O; endproperty
  a_ce_hiz: assert property (p_ce_hiz) else $error("data driven while deselected");
  property p_oe_gate; OE_N_I[*5] |-> !DQ_OE_O; endproperty
  a_oe_gate: assert property (p_oe_gate) else $error("data driven with outputs off");
  property p_standby; CE_N_I[*5] |-> STANDBY_O; endproperty
  a_standby: assert property (p_standby) else $error("no standby while deselected");
  property p_rst_block; (!RST_N_I)[*5] |-> AUTO_RST_O && !WSTROBE_O && !PGM_GO_O && !ERASE_GO_O;
  endproperty
  a_rst_block: assert property (p_rst_block) else $error("activity during device reset");
  property p_rst_async; !RST_N_I ##1 (RST_N_I && !CFG_WR_I)[*6] |-> !SYNC_MODE_O; endproperty
  a_rst_async: assert property (p_rst_async) else $error("burst mode kept over reset");
  property p_wr; s_wr_edge |-> ##[1:6] WSTROBE_O; endproperty
  a_wr: assert property (p_wr) else $error("write edge not captured");
  property p_wr_val; WSTROBE_O |-> WDATA_O == $past(DQ_I, 4) && ADDR_O == $past(ADDR_I, 4);
  endproperty
  a_wr_val: assert property (p_wr_val) else $error("write latch holds wrong word");
  property p_lock_pgm; s_wp_lo ##0 (PGM_REQ_I && lockable) |=> STATUS_O[ST_LOCKED_BIT]
    && STATUS_O[ST_PGM_ERR_BIT] && !PGM_GO_O; endproperty
  a_lock_pgm: assert property (p_lock_pgm) else $error("locked program accepted");
  property p_lock_ers; s_wp_lo ##0 (ERASE_REQ_I && lockable) |=> STATUS_O[ST_LOCKED_BIT]
    && STATUS_O[ST_ERASE_ERR_BIT] && !ERASE_GO_O; endproperty
  a_lock_ers: assert property (p_lock_ers) else $error("locked erase accepted");
  property p_unlock; (WP_N_I && RST_N_I)[*5] ##0 PGM_REQ_I |=> PGM_GO_O; endproperty
  a_unlock: assert property (p_unlock) else $error("unprotected program refused");
  property p_wait_gate; CE_N_I[*5] |-> !WAIT_OE_O; endproperty
  a_wait_gate: assert property (p_wait_gate) else $error("wait driven while deselected");
endmodule : ffb_chk

bind ffb_pin_logic ffb_chk u_chk (.CORE_CLK_I, .NRST_I, .ADDR_I, .DQ_I, .CE_N_I, .OE_N_I,
  .WE_N_I, .WP_N_I, .RST_N_I, .TOP_BOOT_I, .CFG_WR_I, .PGM_REQ_I, .ERASE_REQ_I, .DQ_OE_O,
  .ADDR_O, .WDATA_O, .WSTROBE_O, .PGM_GO_O, .ERASE_GO_O, .STATUS_O, .AUTO_RST_O, .STANDBY_O,
  .SYNC_MODE_O, .WAIT_OE_O);

// ==== ffb_host.sv ====
// behavioural host bus controller that drives the flash pins
module ffb_host
  import ffb_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic [DATA_W-1:0] dev_dq_i, // device read data
  input wire logic dev_oe_i, // device drives data
  output logic [DATA_W-1:0] dq_o, // resolved data bus
  output logic [ADDR_W-1:0] addr_o, // address pins
  output logic ce_n_o, // chip select
  output logic oe_n_o, // output enable
  output logic we_n_o, // write strobe
  output logic adv_n_o, // address valid
  output logic bclk_o // burst clock
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] drv = 16'h0000;
  // released bus shows the inverse of the last word so stale data never matches
  assign dq_o = dev_oe_i ? dev_dq_i : drv;
  initial
  begin
    addr_o = ADDR_RST;
    ce_n_o = 1'b1;
    oe_n_o = 1'b1;
    we_n_o = 1'b1;
    adv_n_o = 1'b0;
    bclk_o = 1'b0;
  end
  task automatic tick(input int n); repeat (n) @(posedge clk_i); endtask : tick
  task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    addr_o <= a;
    drv <= d;
    oe_n_o <= 1'b1;
    ce_n_o <= 1'b0;
    tick(1);
    we_n_o <= 1'b0;
    tick(4);
    we_n_o <= 1'b1;
    tick(4);
    ce_n_o <= 1'b1;
    drv <= ~d;
    tick(4);
  endtask : write_word
  task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
    output logic ok);
    addr_o <= a;
    adv_n_o <= 1'b0;
    ce_n_o <= 1'b0;
    tick(1);
    oe_n_o <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 12 && !ok; i++)
    begin
      tick(1);
      ok = dev_oe_i === 1'b1;
    end
    tick(2);
    d = dev_dq_i;
    idle();
  endtask : read_word
  task automatic burst(input logic [ADDR_W-1:0] a, input int n);
    addr_o <= a;
    ce_n_o <= 1'b0;
    oe_n_o <= 1'b0;
    tick(4);
    repeat (n)
    begin
      bclk_o <= 1'b1;
      tick(4);
      bclk_o <= 1'b0;
      tick(4);
    end
  endtask : burst
  task automatic adv_latch(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    addr_o <= a;
    adv_n_o <= 1'b0;
    ce_n_o <= 1'b0;
    tick(4);
    adv_n_o <= 1'b1;
    tick(4);
    addr_o <= b;
    tick(4);
    idle();
  endtask : adv_latch
  task automatic idle();
    oe_n_o <= 1'b1;
    ce_n_o <= 1'b1;
    tick(5);
  endtask : idle
endmodule : ffb_host

// ==== tb_flash_host_bus_pin_logic.sv ====
// self-checking bench for the flash bus pin logic
module tb_flash_host_bus_pin_logic
  import ffb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, nrst = 1'b0, rst_pin = 1'b0, wp_n = 1'b0, top = 1'b0, bdv = 1'b0;
  logic cfg_wr = 1'b0, mode_wr = 1'b0, pgm_req = 1'b0, ers_req = 1'b0, st_clr = 1'b0;
  ffb_read_cfg_t cfg = CFG_RST;
  ffb_read_mode_t mode = RD_ARRAY;
  logic [DATA_W-1:0] arr_d = 16'h0000, id_d = 16'h0000, dq_bus, dq_o, wdata;
  logic [ADDR_W-1:0] addr, addr_o;
  logic ce_n, oe_n, we_n, adv_n, bclk, dq_oe, wstb, bstart, bstep, pgm_go, ers_go;
  logic auto_rst, standby, sync_mode, wait_n, wait_oe;
  logic [STAT_W-1:0] status;
  int err_total = 0, checks_done = 0, nwr = 0, nbs = 0, nst = 0;
  int b_wr = 0, b_bs = 0, b_st = 0;
  ffb_pin_logic uut (.CORE_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .DQ_I(dq_bus),
    .DQ_O(dq_o), .DQ_OE_O(dq_oe), .CE_N_I(ce_n), .OE_N_I(oe_n), .WE_N_I(we_n),
    .ADDR_VALID_N_I(adv_n), .BURST_CLK_I(bclk), .WP_N_I(wp_n), .RST_N_I(rst_pin),
    .TOP_BOOT_I(top), .CFG_WR_I(cfg_wr), .CFG_I(cfg), .MODE_WR_I(mode_wr), .MODE_I(mode),
    .ARRAY_DATA_I(arr_d), .IDENT_DATA_I(id_d), .BURST_DATA_VALID_I(bdv), .PGM_REQ_I(pgm_req),
    .ERASE_REQ_I(ers_req), .STATUS_CLR_I(st_clr), .ADDR_O(addr_o), .WDATA_O(wdata),
    .WSTROBE_O(wstb), .BURST_START_O(bstart), .BURST_STEP_O(bstep), .PGM_GO_O(pgm_go),
    .ERASE_GO_O(ers_go), .STATUS_O(status), .AUTO_RST_O(auto_rst), .STANDBY_O(standby),
    .SYNC_MODE_O(sync_mode), .WAIT_N_O(wait_n), .WAIT_OE_O(wait_oe));
  ffb_host host (.clk_i(clk), .dev_dq_i(dq_o), .dev_oe_i(dq_oe), .dq_o(dq_bus),
    .addr_o(addr), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n), .adv_n_o(adv_n), .bclk_o(bclk));
  // ----------------------------------------------------------------
  // clock, pulse counters and helpers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (wstb === 1'b1) nwr++;
    if (bstart === 1'b1) nbs++;
    if (bstep === 1'b1) nst++;
  end
  task automatic cyc(input int n); repeat (n) @(posedge clk); endtask : cyc
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic set_cfg(input ffb_read_cfg_t c);
    cfg <= c;
    cfg_wr <= 1'b1;
    cyc(1);
    cfg_wr <= 1'b0;
    cyc(2);
  endtask : set_cfg
  task automatic set_mode(input ffb_read_mode_t m);
    mode <= m;
    mode_wr <= 1'b1;
    cyc(1);
    mode_wr <= 1'b0;
    cyc(2);
  endtask : set_mode
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // lock table: top boot, write protect, erase, block lockable
  localparam logic [ADDR_W-1:0] LK_A [6] = '{19'h08000, 19'h7E000, 19'h7D000, 19'h01000,
    19'h02000, 19'h70000};
  localparam logic [0:5] LK_TOP = 6'h38, LK_WP = 6'h20, LK_ERS = 6'h1C, LK_LK = 6'h35;
  initial
  begin
    logic [DATA_W-1:0] d;
    logic ok;
    logic fail;
    cyc(2);
    nrst <= 1'b1;
    cyc(3);
    rst_pin <= 1'b1;
    cyc(8);
    check(standby, 1'b1);
    check(dq_oe, 1'b0);
    host.write_word(19'h4A5C3, 16'hBEEF);
    check(nwr, 1);
    check(addr_o, 19'h4A5C3);
    check(wdata, 16'hBEEF);
    arr_d <= 16'hC0DE;
    host.read_word(19'h20F0F, d, ok);
    check(ok, 1'b1);
    check(d, 16'hC0DE);
    set_mode(RD_IDENT);
    id_d <= 16'h0A5A;
    host.read_word(19'h00001, d, ok);
    check(ok, 1'b1);
    check(d, 16'h0A5A);
    host.adv_latch(19'h31111, 19'h02222);
    check(addr_o, 19'h31111);
    for (int i = 0; i < 6; i++)
    begin
      top <= LK_TOP[i];
      wp_n <= LK_WP[i];
      host.read_word(LK_A[i], d, ok);
      check(ok, 1'b1);
      st_clr <= 1'b1;
      cyc(1);
      st_clr <= 1'b0;
      if (LK_ERS[i]) ers_req <= 1'b1;
      else pgm_req <= 1'b1;
      cyc(1);
      ers_req <= 1'b0;
      pgm_req <= 1'b0;
      cyc(1);
      fail = LK_LK[i] && !LK_WP[i];
      check(LK_ERS[i] ? ers_go : pgm_go, !fail);
      check(status, fail ? (LK_ERS[i] ? 8'h22 : 8'h12) : 8'h00);
    end
    set_mode(RD_STATUS);
    host.read_word(19'h00000, d, ok);
    check(ok, 1'b1);
    check(d, 16'h0012);
    for (int fe = 0; fe < 2; fe++)
    begin
      set_cfg('{sync_burst: 1'b1, falling_edge: fe[0], continuous: 1'b1});
      check(sync_mode, 1'b1);
      bdv <= 1'b0;
      b_bs = nbs;
      b_st = nst;
      host.burst(fe[0] ? 19'h10008 : 19'h10004, 3);
      // let the last step pulse reach the counters before reading them
      cyc(2);
      check({wait_oe, wait_n}, 2'h2);
      check(nbs - b_bs, 1);
      check(nst - b_st, 2);
      check(addr_o, fe[0] ? 19'h10008 : 19'h10004);
      bdv <= 1'b1;
      cyc(4);
      check(wait_n, 1'b1);
      host.idle();
    end
    rst_pin <= 1'b0;
    cyc(6);
    check({auto_rst, standby}, 2'h3);
    b_wr = nwr;
    host.write_word(19'h00123, 16'h5A5A);
    check(nwr - b_wr, 0);
    rst_pin <= 1'b1;
    cyc(6);
    check(sync_mode, 1'b0);
    b_bs = nbs;
    b_st = nst;
    host.burst(19'h10008, 2);
    check(nbs + nst - b_bs - b_st, 0);
    check(dq_bus, 16'hC0DE);
    host.idle();
    conclude();
  end
endmodule : tb_flash_host_bus_pin_logic
